// >>> include/dcp_pkg.sv
// Purpose: shared types and constants for the connection preemption framer
// Assumes: frames arrive and leave as parsed descriptors, one per cycle
// Notes:   delimiter and frame kinds are abstract codes, not wire symbols
package dcp_pkg;
  // ==========================================================
  // Frame header fields
  localparam int ID_W          = 24;
  localparam int FCTL_W        = 24;
  localparam int LEN_W         = 12;
  localparam int FCTL_EC_BIT   = 18;
  localparam int FCTL_UNI_BIT  = 8;
  localparam int W4_PREEMPT    = 31;
  localparam int W4_PRIO_HI    = 30;
  localparam int W4_PRIO_LO    = 24;
  localparam int PRIO_W        = W4_PRIO_HI - W4_PRIO_LO + 1;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int EDTOV_MS_NS   = 1000000;
  localparam int EDTOV_NS_NS   = 1;
  localparam int CYC_PER_MS    = EDTOV_MS_NS / CLK_PERIOD_NS;
  localparam int CYC_PER_NS    =
    (EDTOV_NS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Codes
  typedef enum logic [1:0] {
    SOF_C1 = 2'h0, SOF_I1 = 2'h1, SOF_N1 = 2'h2, SOF_OTHER = 2'h3
  } dcp_sof_t;
  typedef enum logic [1:0] {
    EOF_N = 2'h0, EOF_T = 2'h1, EOF_DT = 2'h2, EOF_OTHER = 2'h3
  } dcp_eof_t;
  typedef enum logic [3:0] {
    FT_DATA = 4'h0, FT_ACK1 = 4'h1, FT_ACKN = 4'h2, FT_ACK0 = 4'h3,
    FT_PBSY = 4'h4, FT_PRJT = 4'h5, FT_FBSY = 4'h6, FT_FRJT = 4'h7,
    FT_PRMT = 4'h8, FT_OTHER = 4'hF
  } dcp_ftype_t;
  typedef enum logic [2:0] {
    OUT_EST = 3'h0, OUT_FRJT = 3'h1, OUT_FBSY = 3'h2,
    OUT_PBSY = 3'h3, OUT_PRJT = 3'h4, OUT_TMO = 3'h5
  } dcp_outcome_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_SEND = 3'h1, ST_WAIT = 3'h2,
    ST_INIT = 3'h3, ST_RECP = 3'h4
  } dcp_state_t;
  // ==========================================================
  // Frame descriptor
  typedef struct packed {
    dcp_sof_t            sof;
    dcp_eof_t            eof;
    dcp_ftype_t          ftype;
    logic [ID_W-1:0]     dId;
    logic [ID_W-1:0]     sId;
    logic [FCTL_W-1:0]   fctl;
    logic [31:0]         word4;
    logic [LEN_W-1:0]    len;
  } dcp_frame_t;
endpackage

// >>> logic/dcp_framer.sv
// Purpose: preemptor, preempted port and preemption target frame logic
// Assumes: rx and tx descriptors come from logic on ref_clk
// Notes:   one tx slot; rx is held off while any tx frame, answer or request, is still queued
`timescale 1ns/10ps
module dcp_framer #(
  parameter int CYC_PER_MS = dcp_pkg::CYC_PER_MS,
  parameter int TOV_W      = 32,
  parameter int SEQ_W      = 4,
  parameter int PRE_W      = 16
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // Port identity and login values
  input  wire logic [dcp_pkg::ID_W-1:0]    ownId,
  input  wire logic [TOV_W-1:0]            edtovVal,
  input  wire logic                        edtovMsRes,
  input  wire logic [dcp_pkg::LEN_W-1:0]   fabricMaxLen,
  input  wire logic [dcp_pkg::LEN_W-1:0]   destMaxLen,
  input  wire logic [SEQ_W-1:0]            maxSeq,
  // Upper layer request
  input  wire logic                        startReq,
  input  wire logic [dcp_pkg::ID_W-1:0]    startDest,
  input  wire logic                        startUnidir,
  input  wire logic [dcp_pkg::PRIO_W-1:0]  startPrio,
  input  wire logic [dcp_pkg::LEN_W-1:0]   startLen,
  input  wire logic                        startEnd,
  output logic                             startTaken_r,
  // Target policy
  input  wire logic                        portBusy,
  input  wire logic                        portDecline,
  input  wire logic [1:0]                  ackKind,
  input  wire logic                        ownConnPending,
  input  wire logic                        stackedMode,
  // Sequence bookkeeping while connected
  input  wire logic                        seqOpen,
  input  wire logic                        seqClose,
  output logic                             seqAllow_r,
  output logic                             seqHold_r,
  // Receive frames
  input  wire logic                        rxValid,
  input  wire dcp_pkg::dcp_frame_t         rxFrame,
  output logic                             rxReady_r,
  // Transmit frames
  output logic                             txValid_r,
  output dcp_pkg::dcp_frame_t              txFrame_r,
  input  wire logic                        txReady,
  // Status
  output logic                             outcomeValid_r,
  output dcp_pkg::dcp_outcome_t            outcome_r,
  output logic                             roleInit_r,
  output logic                             roleRecp_r,
  output logic                             preemptedNotify_r,
  output logic                             linkResetReq_r,
  output logic                             requeuePreempt_r,
  output logic                             requeueOwn_r,
  output logic                             creditAdj_r
);
  // ==========================================================
  // State
  dcp_pkg::dcp_state_t   state_r, state_nxt;
  logic [dcp_pkg::ID_W-1:0] dest_r;
  logic [TOV_W-1:0]      tmr_r;
  logic [PRE_W-1:0]      pre_r;
  logic [SEQ_W-1:0]      seqCnt_r, seqCnt_nxt;
  dcp_pkg::dcp_frame_t   reqFrame, ansFrame;
  // ==========================================================
  // Receive decode
  wire rxTake   = rxValid && rxReady_r;
  wire toMe     = rxFrame.dId == ownId;
  wire fromDest = rxFrame.sId == dest_r;
  wire sofN1    = rxFrame.sof == dcp_pkg::SOF_N1;
  wire sofC1    = rxFrame.sof == dcp_pkg::SOF_C1;
  wire eofDt    = rxFrame.eof == dcp_pkg::EOF_DT;
  wire eofNT    = rxFrame.eof == dcp_pkg::EOF_N ||
                  rxFrame.eof == dcp_pkg::EOF_T;
  wire isAck    = rxFrame.ftype == dcp_pkg::FT_ACK1 ||
                  rxFrame.ftype == dcp_pkg::FT_ACKN ||
                  rxFrame.ftype == dcp_pkg::FT_ACK0;
  wire isPortNo = rxFrame.ftype == dcp_pkg::FT_PBSY ||
                  rxFrame.ftype == dcp_pkg::FT_PRJT;
  wire isFabNo  = rxFrame.ftype == dcp_pkg::FT_FBSY ||
                  rxFrame.ftype == dcp_pkg::FT_FRJT;
  wire rspAck   = rxTake && toMe && fromDest && sofN1 && eofNT && isAck;
  wire rspPort  = rxTake && toMe && fromDest && sofN1 && eofDt
                  && isPortNo;
  wire rspFab   = rxTake && toMe && sofN1 && eofDt && isFabNo;
  wire connIn   = rxTake && toMe && sofC1 &&
                  rxFrame.ftype == dcp_pkg::FT_DATA;
  wire preqIn   = connIn && rxFrame.word4[dcp_pkg::W4_PREEMPT];
  wire prmtIn   = rxTake && toMe && eofDt &&
                  rxFrame.ftype == dcp_pkg::FT_PRMT;
  wire rmInit   = prmtIn && sofC1 && state_r == dcp_pkg::ST_INIT;
  wire rmRecp   = prmtIn && sofN1 && state_r == dcp_pkg::ST_RECP;
  // ==========================================================
  // Timeout: ns units take one cycle each, a 1 ns unit rounds up
  wire unitTick = edtovMsRes ?
                  (pre_r == PRE_W'(CYC_PER_MS - 1)) : 1'b1;
  // A tick completes one unit, so fire on the edtovVal-th tick, not after
  wire [TOV_W-1:0] unitsDone = tmr_r + TOV_W'(1);
  wire timeout  = state_r == dcp_pkg::ST_WAIT && unitTick &&
                  unitsDone >= edtovVal;
  // ==========================================================
  // Destination answer selection
  wire idleTgt  = state_r == dcp_pkg::ST_IDLE;
  wire wasConn  = state_r == dcp_pkg::ST_INIT ||
                  state_r == dcp_pkg::ST_RECP;
  wire ansBusy  = preqIn && idleTgt && portBusy;
  wire ansRej   = preqIn && idleTgt && !portBusy && portDecline;
  wire ansAck   = preqIn && (wasConn ||
                  (idleTgt && !portBusy && !portDecline));
  wire inWait   = state_r == dcp_pkg::ST_WAIT;
  wire waitIn   = inWait && connIn;
  wire waitAck  = waitIn && !portBusy;
  wire ansLoad  = ansBusy || ansRej || ansAck || waitIn;
  wire ownRq    = preqIn && idleTgt && ownConnPending;
  dcp_pkg::dcp_ftype_t ackType;
  assign ackType = ackKind == 2'h0 ? dcp_pkg::FT_ACK1 :
                   ackKind == 2'h1 ? dcp_pkg::FT_ACKN :
                   dcp_pkg::FT_ACK0;
  wire useAck   = ansAck || waitAck;
  always_comb begin
    ansFrame       = '0;
    ansFrame.sof   = dcp_pkg::SOF_N1;
    ansFrame.sId   = ownId;
    ansFrame.dId   = rxFrame.sId;
    ansFrame.eof   = useAck ? dcp_pkg::EOF_N : dcp_pkg::EOF_DT;
    ansFrame.ftype = useAck ? ackType :
                     ansRej ? dcp_pkg::FT_PRJT : dcp_pkg::FT_PBSY;
  end
  // ==========================================================
  // Preemption request build
  wire [dcp_pkg::LEN_W-1:0] limLen = fabricMaxLen < destMaxLen ?
                                     fabricMaxLen : destMaxLen;
  wire startGo = startReq && idleTgt && !txValid_r && !rxTake;
  always_comb begin
    reqFrame       = '0;
    reqFrame.sof   = dcp_pkg::SOF_C1;
    reqFrame.ftype = dcp_pkg::FT_DATA;
    reqFrame.sId   = ownId;
    reqFrame.dId   = startDest;
    reqFrame.eof   = startEnd ? dcp_pkg::EOF_T : dcp_pkg::EOF_N;
    reqFrame.word4[dcp_pkg::W4_PREEMPT] = 1'b1;
    reqFrame.word4[dcp_pkg::W4_PRIO_HI:dcp_pkg::W4_PRIO_LO] = startPrio;
    reqFrame.fctl[dcp_pkg::FCTL_EC_BIT] = 1'b0;
    reqFrame.fctl[dcp_pkg::FCTL_UNI_BIT] = startUnidir;
    reqFrame.len   = startLen < limLen ? startLen : limLen;
  end
  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dcp_pkg::ST_IDLE: begin
        if (ansAck) state_nxt = dcp_pkg::ST_RECP;
        else if (startGo) state_nxt = dcp_pkg::ST_SEND;
      end
      dcp_pkg::ST_SEND: begin
        if (txReady) state_nxt = dcp_pkg::ST_WAIT;
      end
      dcp_pkg::ST_WAIT: begin
        if (rspAck) state_nxt = dcp_pkg::ST_INIT;
        else if (waitAck) state_nxt = dcp_pkg::ST_RECP;
        else if (rspPort || rspFab || timeout || waitIn)
          state_nxt = dcp_pkg::ST_IDLE;
      end
      dcp_pkg::ST_INIT, dcp_pkg::ST_RECP: begin
        if (ansAck) state_nxt = dcp_pkg::ST_RECP;
        else if (rmInit || rmRecp) state_nxt = dcp_pkg::ST_IDLE;
      end
      default: state_nxt = dcp_pkg::ST_IDLE;
    endcase
  end
  // Sequence count is only meaningful while we initiate
  wire seqUp = seqOpen && seqAllow_r;
  wire seqDn = seqClose && seqCnt_r != '0;
  always_comb begin
    seqCnt_nxt = seqCnt_r;
    if (state_nxt != dcp_pkg::ST_INIT) seqCnt_nxt = '0;
    else if (seqUp && !seqDn) seqCnt_nxt = seqCnt_r + SEQ_W'(1);
    else if (seqDn && !seqUp) seqCnt_nxt = seqCnt_r - SEQ_W'(1);
  end
  // A response frame beats a timeout landing in the same cycle
  wire [2:0] outSel = rspAck ? dcp_pkg::OUT_EST :
    (rspFab && rxFrame.ftype == dcp_pkg::FT_FRJT) ? dcp_pkg::OUT_FRJT :
    rspFab ? dcp_pkg::OUT_FBSY :
    (rspPort && rxFrame.ftype == dcp_pkg::FT_PBSY) ? dcp_pkg::OUT_PBSY :
    rspPort ? dcp_pkg::OUT_PRJT : dcp_pkg::OUT_TMO;
  wire outFire = inWait && (rspAck || rspFab || rspPort ||
                 (timeout && !waitIn));
  wire txLoad  = ansLoad || startGo;
  wire txBusyN = txValid_r && !txReady;
  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r  <= dcp_pkg::ST_IDLE;
      seqCnt_r <= '0;
      dest_r   <= '0;
    end else begin
      state_r  <= state_nxt;
      seqCnt_r <= seqCnt_nxt;
      if (startGo) dest_r <= startDest;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst || !inWait) begin
      tmr_r <= '0;
      pre_r <= '0;
    end else begin
      pre_r <= unitTick ? '0 : pre_r + PRE_W'(1);
      if (unitTick) tmr_r <= tmr_r + TOV_W'(1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      txValid_r <= 1'b0;
      txFrame_r <= '0;
      rxReady_r <= 1'b0;
    end else begin
      txValid_r <= txLoad || txBusyN;
      if (txLoad) txFrame_r <= ansLoad ? ansFrame : reqFrame;
      rxReady_r <= !(txLoad || txBusyN);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      outcomeValid_r    <= 1'b0;
      outcome_r         <= dcp_pkg::OUT_EST;
      startTaken_r      <= 1'b0;
      preemptedNotify_r <= 1'b0;
      linkResetReq_r    <= 1'b0;
      requeuePreempt_r  <= 1'b0;
      requeueOwn_r      <= 1'b0;
      creditAdj_r       <= 1'b0;
    end else begin
      outcomeValid_r    <= outFire;
      if (outFire) outcome_r <= dcp_pkg::dcp_outcome_t'(outSel);
      startTaken_r      <= startGo;
      preemptedNotify_r <= rmInit || rmRecp;
      linkResetReq_r    <= timeout && !rspAck && !rspFab && !rspPort
                           && !waitIn;
      requeuePreempt_r  <= waitIn;
      requeueOwn_r      <= ownRq && !stackedMode;
      creditAdj_r       <= ownRq;
    end
  end
  // Roles and sequence gating; a new connection runs ordinary rules
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      roleInit_r <= 1'b0;
      roleRecp_r <= 1'b0;
      seqHold_r  <= 1'b0;
      seqAllow_r <= 1'b0;
    end else begin
      roleInit_r <= state_nxt == dcp_pkg::ST_INIT;
      roleRecp_r <= state_nxt == dcp_pkg::ST_RECP;
      seqHold_r  <= state_nxt == dcp_pkg::ST_SEND ||
                    state_nxt == dcp_pkg::ST_WAIT;
      seqAllow_r <= state_nxt == dcp_pkg::ST_INIT &&
                    seqCnt_nxt < maxSeq;
    end
  end
  // ==========================================================
  // Checks
  wire txReq = txValid_r && txFrame_r.sof == dcp_pkg::SOF_C1 &&
               txFrame_r.ftype == dcp_pkg::FT_DATA;
  a_req_flag: assert property (@(posedge ref_clk) disable iff (srst)
    txReq |-> txFrame_r.word4[dcp_pkg::W4_PREEMPT] && txFrame_r.sId == ownId)
    else $error("request frame lacks flag or own source");
  a_req_endconn: assert property (@(posedge ref_clk) disable iff (srst)
    txReq |-> !txFrame_r.fctl[dcp_pkg::FCTL_EC_BIT])
    else $error("request frame end-connection bit set");
  a_req_unidir: assert property (@(posedge ref_clk) disable iff (srst)
    startGo |=> txFrame_r.fctl[dcp_pkg::FCTL_UNI_BIT] == $past(startUnidir))
    else $error("unidirectional bit wrong");
  a_req_len: assert property (@(posedge ref_clk) disable iff (srst)
    startGo |=> txFrame_r.len <= $past(fabricMaxLen) &&
                txFrame_r.len <= $past(destMaxLen))
    else $error("request payload over limit");
  a_hold_wait: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == dcp_pkg::ST_WAIT |-> seqHold_r && !seqAllow_r)
    else $error("sequences not held while waiting");
  a_ack_conn: assert property (@(posedge ref_clk) disable iff (srst)
    inWait && rspAck |=> roleInit_r && outcomeValid_r &&
                         outcome_r == dcp_pkg::OUT_EST)
    else $error("ACK did not establish connection");
  a_fab_fail: assert property (@(posedge ref_clk) disable iff (srst)
    inWait && rspFab |=> outcomeValid_r && !roleInit_r &&
      (outcome_r == dcp_pkg::OUT_FRJT || outcome_r == dcp_pkg::OUT_FBSY))
    else $error("fabric answer not reported as failure");
  a_port_fail: assert property (@(posedge ref_clk) disable iff (srst)
    inWait && rspPort |=> outcomeValid_r && !roleInit_r &&
      (outcome_r == dcp_pkg::OUT_PBSY || outcome_r == dcp_pkg::OUT_PRJT))
    else $error("port answer not reported as failure");
  a_recp_ack: assert property (@(posedge ref_clk) disable iff (srst)
    ansAck |=> roleRecp_r && txValid_r &&
               txFrame_r.sof == dcp_pkg::SOF_N1 && txFrame_r.sId == ownId)
    else $error("target did not acknowledge and become recipient");
  a_busy_ans: assert property (@(posedge ref_clk) disable iff (srst)
    ansBusy |=> txValid_r && txFrame_r.ftype == dcp_pkg::FT_PBSY &&
                txFrame_r.eof == dcp_pkg::EOF_DT)
    else $error("busy target did not send P_BSY");
  a_timeout_rst: assert property (@(posedge ref_clk) disable iff (srst)
    timeout && !rxTake |=> linkResetReq_r ##1 !linkResetReq_r)
    else $error("timeout did not pulse link reset");
  a_removal: assert property (@(posedge ref_clk) disable iff (srst)
    rmInit || rmRecp |=> preemptedNotify_r && !roleInit_r && !roleRecp_r)
    else $error("removal frame not acted on");
  a_requeue: assert property (@(posedge ref_clk) disable iff (srst)
    waitIn |=> requeuePreempt_r && txValid_r &&
               txFrame_r.sof == dcp_pkg::SOF_N1)
    else $error("incoming connect while waiting not handled");
  c_established: cover property (@(posedge ref_clk) disable iff (srst)
    startGo ##[1:20] (inWait && rspAck));
  c_timeout: cover property (@(posedge ref_clk) disable iff (srst)
    inWait ##1 linkResetReq_r);
  c_target_ack: cover property (@(posedge ref_clk) disable iff (srst)
    ansAck && idleTgt);
  c_preempted: cover property (@(posedge ref_clk) disable iff (srst)
    roleInit_r ##[1:50] preemptedNotify_r);
  c_collide: cover property (@(posedge ref_clk) disable iff (srst)
    waitIn ##1 requeuePreempt_r);
endmodule

// >>> sim/dcp_far_end.sv
// Purpose: far side model, fabric and remote port frame answers
// Assumes: one frame descriptor a cycle each way, on ref_clk
// Notes:   released rx lines show the inverse of the last frame
`timescale 1ns/10ps
module dcp_far_end (
  // Clock
  input  wire logic                ref_clk,
  // Frames from the framer
  input  wire logic                txValid_r,
  input  wire dcp_pkg::dcp_frame_t txFrame_r,
  output logic                     txReady,
  // Frames to the framer
  output logic                     rxValid,
  output dcp_pkg::dcp_frame_t      rxFrame,
  input  wire logic                rxReady_r
);
  // ==========================================================
  // Bench controls and capture
  dcp_pkg::dcp_frame_t lastTx;
  dcp_pkg::dcp_ftype_t respKind = dcp_pkg::FT_ACK1;
  logic                respOn   = 1'b0;
  logic                stuck    = 1'b0;
  int                  stall    = 0;
  initial begin
    txReady = 1'b1;
    rxValid = 1'b0;
    rxFrame = '0;
  end
  // ==========================================================
  // Slow receiver: stalls only while a frame waits
  always @(negedge ref_clk) begin
    if (txValid_r && stall > 0) begin
      stall--;
    end
    txReady = (stall == 0);
  end
  always @(posedge ref_clk) begin
    if (txValid_r && txReady) begin
      lastTx <= txFrame_r;
      if (respOn && txFrame_r.sof == dcp_pkg::SOF_C1 &&
          txFrame_r.word4[31]) begin
        fork
          reply();
        join_none
      end
    end
  end
  // ==========================================================
  // Rx frame held until taken; bound keeps a hang visible
  task automatic send(input dcp_pkg::dcp_frame_t f);
    int n;
    @(negedge ref_clk);
    rxValid = 1'b1;
    rxFrame = f;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!rxReady_r && n < 50);
    stuck = !rxReady_r;
    @(negedge ref_clk);
    rxValid = 1'b0;
    rxFrame = ~f;
  endtask
  // Answer from target or fabric, addressed back to the requester
  task automatic reply();
    dcp_pkg::dcp_frame_t f;
    @(negedge ref_clk);
    f = '0;
    f.sof = dcp_pkg::SOF_N1;
    f.ftype = respKind;
    f.dId = lastTx.sId;
    f.sId = lastTx.dId;
    f.eof = (respKind inside {dcp_pkg::FT_ACK1, dcp_pkg::FT_ACKN,
      dcp_pkg::FT_ACK0}) ? dcp_pkg::EOF_N : dcp_pkg::EOF_DT;
    send(f);
  endtask
endmodule

// >>> sim/test_dcp_framer.sv
// Purpose: self-checking bench for the preemption framer
// Assumes: far side model answers the request frames
// Notes:   ms unit shortened to 4 cycles to keep the run short
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin \
  num_errors++; \
  $display("Error at %0t: got %0h want %0h", $time, (a), (e)); \
  end end
module test_dcp_framer;
  localparam int MS = 4;
  logic ref_clk = 1'b0, srst = 1'b1, edtovMsRes = 1'b0;
  logic [23:0] ownId = 24'h010203, startDest = 24'h0405AB;
  logic [31:0] edtovVal = 32'h3;
  logic [11:0] fabricMaxLen = 12'h200, destMaxLen = 12'h100;
  logic [11:0] startLen = 12'h0;
  logic [6:0] startPrio = 7'h55;
  logic [3:0] maxSeq = 4'h2;
  logic [1:0] ackKind = 2'h0;
  logic startReq = 0, startUnidir = 0, startEnd = 0, startTaken_r;
  logic portBusy = 0, portDecline = 0, ownConnPending = 0;
  logic stackedMode = 0, seqOpen = 0, seqClose = 0;
  logic seqAllow_r, seqHold_r, rxValid, rxReady_r, txValid_r, txReady;
  logic outcomeValid_r, roleInit_r, roleRecp_r, preemptedNotify_r;
  logic linkResetReq_r, requeuePreempt_r, requeueOwn_r, creditAdj_r;
  dcp_pkg::dcp_frame_t rxFrame, txFrame_r, f;
  dcp_pkg::dcp_outcome_t outcome_r, gotOut;
  logic [5:0] seen = '0;
  int num_errors = 0, checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  dcp_framer #(.CYC_PER_MS(MS)) dut_u (.ref_clk, .srst, .ownId,
    .edtovVal, .edtovMsRes, .fabricMaxLen, .destMaxLen, .maxSeq,
    .startReq, .startDest, .startUnidir, .startPrio, .startLen, .startEnd,
    .startTaken_r, .portBusy, .portDecline, .ackKind, .ownConnPending,
    .stackedMode, .seqOpen, .seqClose, .seqAllow_r, .seqHold_r, .rxValid,
    .rxFrame, .rxReady_r, .txValid_r, .txFrame_r, .txReady, .outcomeValid_r,
    .outcome_r, .roleInit_r, .roleRecp_r, .preemptedNotify_r,
    .linkResetReq_r, .requeuePreempt_r, .requeueOwn_r, .creditAdj_r);
  dcp_far_end far_u (.ref_clk, .txValid_r, .txFrame_r, .txReady, .rxValid,
    .rxFrame, .rxReady_r);
  // ==========================================================
  // Pulses are one cycle wide, so keep them sticky from each start or push
  always @(posedge ref_clk) begin
    seen <= seen | {outcomeValid_r, creditAdj_r, requeueOwn_r,
      requeuePreempt_r, linkResetReq_r, preemptedNotify_r};
    if (outcomeValid_r) begin
      gotOut <= outcome_r;
    end
  end
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    $display("Error at %0t: wait bound used up", $time);
    print_verdict();
  endtask
  function automatic dcp_pkg::dcp_frame_t mk(dcp_pkg::dcp_sof_t s,
      dcp_pkg::dcp_ftype_t t, logic [23:0] src, logic flag);
    mk = '0;
    mk.sof = s;
    mk.ftype = t;
    mk.eof = (t == dcp_pkg::FT_PRMT) ? dcp_pkg::EOF_DT : dcp_pkg::EOF_N;
    mk.dId = ownId;
    mk.sId = src;
    mk.word4[31] = flag;
  endfunction
  task automatic push(input dcp_pkg::dcp_frame_t fr);
    seen = '0;
    far_u.send(fr);
    if (far_u.stuck) hang();
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic start(input logic uni, input logic [11:0] len);
    int n;
    @(negedge ref_clk);
    seen = '0;
    {startReq, startUnidir, startLen} = {1'b1, uni, len};
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!startTaken_r && n < 20);
    startReq = 1'b0;
    if (!startTaken_r) hang();
    `CHK(seqHold_r, 1'b1)
  endtask
  task automatic wait_out(output int n);
    n = 0;
    while (!seen[5] && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    if (!seen[5]) hang();
  endtask
  task automatic chk_req(input logic uni, input logic [11:0] len);
    f = far_u.lastTx;
    `CHK({f.sof, f.ftype}, {dcp_pkg::SOF_C1, dcp_pkg::FT_DATA})
    `CHK({f.sId, f.dId, f.word4[31]}, {ownId, startDest, 1'b1})
    `CHK(f.eof, startEnd ? dcp_pkg::EOF_T : dcp_pkg::EOF_N)
    `CHK({f.fctl[18], f.fctl[8]}, {1'b0, uni})
    `CHK(f.len, len)
    `CHK(f.word4[30:24], startPrio)
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_accept();
    int n;
    far_u.respKind = dcp_pkg::FT_ACK1;
    far_u.respOn = 1'b1;
    far_u.stall = 2;
    startEnd = 1'b1;
    start(1'b0, 12'h7FF);
    wait_out(n);
    chk_req(1'b0, destMaxLen);
    `CHK(gotOut, dcp_pkg::OUT_EST)
    `CHK({roleInit_r, seqHold_r, seqAllow_r}, 3'b101)
    repeat (4) begin
      @(negedge ref_clk);
      seqOpen = ~seqOpen;
    end
    repeat (2) @(negedge ref_clk);
    `CHK(seqAllow_r, 1'b0)
    seqClose = 1'b1;
    @(negedge ref_clk);
    seqClose = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK(seqAllow_r, 1'b1)
    push(mk(dcp_pkg::SOF_C1, dcp_pkg::FT_PRMT, 24'h0A0B0C, 1'b0));
    `CHK({seen[0], roleInit_r}, 2'b10)
    startEnd = 1'b0;
    $display("Test accept done");
  endtask
  task automatic t_refuse();
    int n;
    dcp_pkg::dcp_ftype_t k[4] = '{dcp_pkg::FT_FRJT, dcp_pkg::FT_FBSY,
      dcp_pkg::FT_PBSY, dcp_pkg::FT_PRJT};
    dcp_pkg::dcp_outcome_t o[4] = '{dcp_pkg::OUT_FRJT, dcp_pkg::OUT_FBSY,
      dcp_pkg::OUT_PBSY, dcp_pkg::OUT_PRJT};
    for (int i = 0; i < 4; i++) begin
      far_u.respKind = k[i];
      start(i[0], 12'h040);
      wait_out(n);
      chk_req(i[0], 12'h040);
      `CHK(gotOut, o[i])
      `CHK(roleInit_r, 1'b0)
    end
    $display("Test refuse done");
  endtask
  task automatic t_timeout();
    int n, e;
    far_u.respOn = 1'b0;
    for (int ms = 0; ms < 2; ms++) begin
      edtovMsRes = ms[0];
      e = ms ? 3 * MS : 3;
      start(1'b0, 12'h010);
      wait_out(n);
      `CHK({gotOut, seen[1]}, {dcp_pkg::OUT_TMO, 1'b1})
      `CHK(n >= e - 1 && n <= e + 5, 1'b1)
    end
    $display("Test timeout done");
  endtask
  task automatic t_collide();
    start(1'b1, 12'h020);
    push(mk(dcp_pkg::SOF_C1, dcp_pkg::FT_DATA, 24'h0000AA, 1'b0));
    f = far_u.lastTx;
    `CHK({seen[2], seen[5]}, 2'b10)
    `CHK({f.sof, f.ftype}, {dcp_pkg::SOF_N1, dcp_pkg::FT_ACK1})
    push(mk(dcp_pkg::SOF_N1, dcp_pkg::FT_PRMT, 24'h0A0B0C, 1'b0));
    `CHK({seen[0], roleRecp_r}, 2'b10)
    $display("Test collide done");
  endtask
  task automatic t_target();
    dcp_pkg::dcp_ftype_t a[3] = '{dcp_pkg::FT_ACK1, dcp_pkg::FT_ACKN,
      dcp_pkg::FT_ACK0};
    {portBusy, portDecline} = 2'b10;
    push(mk(dcp_pkg::SOF_C1, dcp_pkg::FT_DATA, 24'h0000BB, 1'b1));
    f = far_u.lastTx;
    `CHK({f.ftype, f.eof}, {dcp_pkg::FT_PBSY, dcp_pkg::EOF_DT})
    {portBusy, portDecline} = 2'b01;
    push(mk(dcp_pkg::SOF_C1, dcp_pkg::FT_DATA, 24'h0000BB, 1'b1));
    f = far_u.lastTx;
    `CHK({f.ftype, f.eof}, {dcp_pkg::FT_PRJT, dcp_pkg::EOF_DT})
    {portDecline, ownConnPending} = 2'b01;
    for (int i = 0; i < 3; i++) begin
      {ackKind, stackedMode} = {i[1:0], i == 1};
      push(mk(dcp_pkg::SOF_C1, dcp_pkg::FT_DATA, 24'h0000BB, 1'b1));
      f = far_u.lastTx;
      `CHK({f.sof, f.ftype, f.eof}, {dcp_pkg::SOF_N1, a[i], dcp_pkg::EOF_N})
      `CHK({f.sId, f.dId, roleRecp_r}, {ownId, 24'h0000BB, 1'b1})
      `CHK(seen[3], i != 1)
      if (i != 1) `CHK(seen[4], 1'b1)
      push(mk(dcp_pkg::SOF_N1, dcp_pkg::FT_PRMT, 24'h0A0B0C, 1'b0));
      `CHK({seen[0], roleRecp_r}, 2'b10)
    end
    ownConnPending = 1'b0;
    $display("Test target done");
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    `CHK({txValid_r, rxReady_r, roleInit_r, roleRecp_r}, 4'b0100)
    t_accept();
    t_refuse();
    t_timeout();
    t_collide();
    t_target();
    print_verdict();
  end
endmodule
